// ===== rst_seq_regs.svh
// Constants for the reset sequencer and power mode control
`ifndef RST_SEQ_REGS_SVH
`define RST_SEQ_REGS_SVH
`define SEQ_HALF_CLOCKS 1024
`define SEQ_CYCLES (`SEQ_HALF_CLOCKS / 2)
`define CFG_BIDIR_BIT 5
`define CFG_WIDTH 16
`define CNT_WIDTH 10
`endif

// ===== rst_seq_pkg.sv
// Types for the reset sequencer and power mode control
package rst_seq_pkg;
   typedef enum logic [5:0] {
      ST_RUN    = 6'h01,
      ST_HOLD   = 6'h02,
      ST_TRANS  = 6'h04,
      ST_SEQ    = 6'h08,
      ST_EXTEND = 6'h10,
      ST_WDWAIT = 6'h20
   } seq_state_e;
   typedef enum logic [2:0] {
      PM_ACTIVE = 3'h1,
      PM_IDLE   = 3'h2,
      PM_PDOWN  = 3'h4
   } pm_state_e;
endpackage

// ===== seq_counter.sv
// Down counter timing the internal reset sequence
`timescale 1ns/1ps
module seq_counter #(
   parameter int WIDTH = 10,
   parameter logic [WIDTH-1:0] LOAD = '1
) (
   input wire logic clk,          // CPU clock
   input wire logic sys_rst,      // Synchronous reset
   input wire logic load,         // Restart the count
   input wire logic run,          // Count down while high
   output logic done              // Count at zero
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   assign cnt_d = load ? LOAD : ((run && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
   assign done = (cnt_q == '0) && !load;
   always_ff @(posedge clk) begin
      if (sys_rst) cnt_q <= '0;
      else cnt_q <= cnt_d;
   end
endmodule

// ===== rst_seq.sv
// Reset sequencer and power reduction mode control
//
// Function
// - Reset pin low drives internal reset immediately, no clock needed.
// - Release of reset pin is resynchronised before reset is left.
// - Reset pin sampled low with programming supply high starts warm reset.
// - Warm reset immediately floats I/Os and drives reset output low.
// - Transition phase cancels holds, ends internal cycles, aborts bus cycles.
// - Internal reset sequence then lasts 1024 half clocks, 512 cycles.
// - With bidir enable set, reset pin driven low and enable cleared.
// - After sequence, reset pin still low prolongs internal reset.
// - Software reset instruction starts 512-cycle sequence, drives reset pin low.
// - Watchdog overflow starts the reset sequence.
// - Watchdog reset lets bus cycle finish without ready or with ready.
// - Watchdog reset aborts bus cycle when ready sampled inactive.
// - Watchdog resets suppressed in bootstrap loader mode.
// - Bidir reset drives pin for whole watchdog or software sequence.
// - Idle halts CPU only; any interrupt or any software, watchdog or warm reset ends it; cold pin reset does not.
// - Power-down halts all; configurable wake by warm reset or fast pin.
// - Idle or power-down entered only after bus actions finish.
// - Entry refused when ready enabled but not activated on last access.
`timescale 1ns/1ps
`include "rst_seq_regs.svh"
module rst_seq
   import rst_seq_pkg::*;
#(
   parameter int SEQ_LEN = `SEQ_CYCLES
) (
   input wire logic clk,                 // CPU clock
   input wire logic sys_rst,             // Synchronous reset, power-on
   input wire logic reset_input_pin_i,   // Reset pin level, low active
   output logic reset_input_pin_o,       // Reset pin drive value
   output logic reset_input_pin_oe,      // Reset pin drive enable
   output logic reset_output_pin,        // Reset output pin, low active
   input wire logic vpp_pin,             // Programming supply pin
   input wire logic software_reset_instruction, // Software reset pulse
   input wire logic wdt_overflow,        // Watchdog overflow pulse
   input wire logic bootstrap_mode,      // Bootstrap loader active
   input wire logic bidir_reset_enable_wr,  // Config write strobe
   input wire logic bidir_reset_enable_val, // Config write value
   output logic bidir_reset_enable,      // Bidirectional reset enable
   input wire logic bus_active,          // External bus cycle running
   input wire logic bus_uses_ready,      // Running cycle uses ready
   input wire logic waitstates_done,     // Programmed waitstates elapsed
   input wire logic ready_pin,           // Ready pin level
   input wire logic ready_enabled,       // Ready handshake enabled
   input wire logic ready_polarity,      // 1: active high ready
   input wire logic idle_req,            // Idle instruction pulse
   input wire logic pdown_req,           // Power-down instruction pulse
   input wire logic pdown_hw_only,       // Power-down wakes only by hw/fast pin
   input wire logic irq_req,             // Any interrupt request
   input wire logic fast_ext_irq,        // Fast external interrupt pin
   output logic io_float,                // Place I/Os in high impedance
   output logic internal_reset,          // Internal reset, high active
   output logic hold_cancel,             // Cancel pending holds
   output logic bus_abort,               // Abort external bus cycle
   output logic cpu_halt,                // CPU clock stopped
   output logic periph_halt              // Peripheral clocks stopped
);
   seq_state_e st_q;
   seq_state_e st_d;
   pm_state_e pm_q;
   pm_state_e pm_d;
   logic [1:0] rst_sync_q;
   logic sync_low_q;
   logic drive_q;
   logic cold_q;
   logic bidir_q;
   logic ready_seen_q;
   logic seq_done;

   // Two synchroniser stages plus a third, sync_low_q, that feeds the state logic
   always_ff @(posedge clk) begin
      rst_sync_q <= {rst_sync_q[0], reset_input_pin_i};
      sync_low_q <= !rst_sync_q[1];
   end

   wire pin_low = !reset_input_pin_i;
   // Reset pin entry acts without a clock; our own drive is excluded
   wire ext_low = pin_low && !(drive_q && reset_input_pin_oe);
   wire warm_start = sync_low_q && vpp_pin && !drive_q;
   wire sw_start = software_reset_instruction;
   wire wd_start = wdt_overflow && !bootstrap_mode;
   wire ready_active = ready_pin == ready_polarity;
   wire wd_finish = !bus_active || !bus_uses_ready
      || (waitstates_done && ready_active);
   wire wd_abort = bus_active && bus_uses_ready
      && waitstates_done && !ready_active;
   wire in_reset = (st_q != ST_RUN);
   wire new_src = (sw_start || wd_start) && st_q == ST_RUN;
   wire load_cnt = (st_q == ST_TRANS) || (st_q == ST_WDWAIT && (wd_finish || wd_abort))
      || (sw_start && st_q == ST_RUN);

   seq_counter #(
      .WIDTH(`CNT_WIDTH),
      .LOAD(`CNT_WIDTH'(SEQ_LEN - 1))
   ) u_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(load_cnt),
      .run(st_q == ST_SEQ),
      .done(seq_done)
   );

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_RUN: begin
            if (warm_start) st_d = ST_HOLD;
            else if (sw_start) st_d = ST_SEQ;
            else if (wd_start) st_d = ST_WDWAIT;
         end
         ST_HOLD: begin
            if (!sync_low_q) st_d = ST_TRANS;
         end
         ST_TRANS: st_d = ST_SEQ;
         ST_WDWAIT: begin
            // An aborted cycle does not wait for the bus to go idle
            if (wd_finish || wd_abort) st_d = ST_SEQ;
         end
         ST_SEQ: begin
            if (seq_done) st_d = ST_EXTEND;
         end
         ST_EXTEND: begin
            if (!sync_low_q || drive_q) st_d = ST_RUN;
         end
         default: st_d = ST_RUN;
      endcase
   end

   // Drive of the reset pin spans the whole sequence of a bidir reset
   wire drive_set = bidir_q && (st_q == ST_TRANS || new_src);
   wire drive_clr = st_q == ST_EXTEND;

   always_ff @(posedge clk) begin
      if (sys_rst || ext_low && st_q == ST_RUN && !vpp_pin) begin
         st_q <= ST_RUN;
         drive_q <= 1'b0;
         cold_q <= ext_low;
      end else begin
         st_q <= st_d;
         // Cold reset is left only once the pin release has crossed both stages
         if (rst_sync_q[1]) cold_q <= 1'b0;
         if (drive_set || (sw_start && st_q == ST_RUN)) drive_q <= 1'b1;
         else if (drive_clr) drive_q <= 1'b0;
      end
   end

   // Enable bit clears when the sequence starts driving the pin
   always_ff @(posedge clk) begin
      if (sys_rst) bidir_q <= 1'b0;
      else if (drive_set) bidir_q <= 1'b0;
      else if (bidir_reset_enable_wr) bidir_q <= bidir_reset_enable_val;
   end

   // Ready status of the last completed bus access
   always_ff @(posedge clk) begin
      if (sys_rst) ready_seen_q <= 1'b1;
      else if (bus_active && waitstates_done) ready_seen_q <= ready_active;
   end

   wire entry_ok = !bus_active && (!ready_enabled || ready_seen_q);
   wire idle_wake = irq_req || in_reset;
   wire pd_wake = pdown_hw_only ? (fast_ext_irq || st_q == ST_HOLD)
      : (fast_ext_irq || irq_req || in_reset);

   always_comb begin
      pm_d = pm_q;
      unique case (pm_q)
         PM_ACTIVE: begin
            if (!in_reset && entry_ok && pdown_req) pm_d = PM_PDOWN;
            else if (!in_reset && entry_ok && idle_req) pm_d = PM_IDLE;
         end
         PM_IDLE: begin
            if (idle_wake) pm_d = PM_ACTIVE;
         end
         PM_PDOWN: begin
            if (pd_wake) pm_d = PM_ACTIVE;
         end
         default: pm_d = PM_ACTIVE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) pm_q <= PM_ACTIVE;
      else pm_q <= pm_d;
   end

   // Asynchronous paths: pin low forces reset outputs without a clock edge
   assign internal_reset = sys_rst || ext_low || cold_q || in_reset;
   assign io_float = sys_rst || ext_low || cold_q || st_q == ST_HOLD;
   assign reset_output_pin = !(sys_rst || ext_low || cold_q || in_reset);
   assign hold_cancel = st_q == ST_TRANS;
   assign bus_abort = st_q == ST_TRANS || (st_q == ST_WDWAIT && wd_abort);
   assign reset_input_pin_o = 1'b0;
   assign reset_input_pin_oe = drive_q && !sys_rst;
   assign bidir_reset_enable = bidir_q;
   assign cpu_halt = pm_q != PM_ACTIVE;
   assign periph_halt = pm_q == PM_PDOWN;
endmodule

// ===== ext_reset_model.sv
// Board-side reset circuit: pull-up, push button and the device's own pin drive
`timescale 1ns/1ps
module ext_reset_model (
   input wire logic pin_oe,      // Device drives the pin
   input wire logic pin_o,       // Device drive value
   input wire logic button_low,  // Board pulls the pin low
   output logic pin_level        // Resolved pin level
);
   // Pull-up: a released pin reads high, never the last value driven
   assign pin_level = (pin_oe ? pin_o : 1'b1) & ~button_low;
endmodule

// ===== rst_seq_checker.sv
// Port assertions for the reset sequencer
`timescale 1ns/1ps
module rst_seq_checker #(
   parameter int SEQ_LEN = 8
) (
   input wire logic clk,                        // Clock
   input wire logic sys_rst,                    // Reset
   input wire logic reset_input_pin_i,          // Pin level
   input wire logic reset_input_pin_o,          // Pin value
   input wire logic reset_input_pin_oe,         // Pin enable
   input wire logic vpp_pin,                    // Supply pin
   input wire logic software_reset_instruction, // Sw reset
   input wire logic wdt_overflow,               // Watchdog
   input wire logic bootstrap_mode,             // Loader mode
   input wire logic bidir_reset_enable_wr,      // Cfg write
   input wire logic bidir_reset_enable,         // Cfg bit
   input wire logic bus_active,                 // Bus busy
   input wire logic ready_enabled,              // Ready on
   input wire logic idle_req,                   // Idle request
   input wire logic irq_req,                    // Interrupt
   input wire logic io_float,                   // I/O float
   input wire logic internal_reset,             // Reset out
   input wire logic cpu_halt,                   // CPU halt
   input wire logic periph_halt                 // Periph halt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire run = !internal_reset && reset_input_pin_i;
   sequence sw_take; software_reset_instruction && run; endsequence
   sequence seq_body; (internal_reset && reset_input_pin_oe)[*8]; endsequence
   a_cold_entry: assert property (!reset_input_pin_i && !vpp_pin |-> internal_reset)
      else $error("cold reset not applied");
   a_sw_sequence: assert property (sw_take |=> seq_body)
      else $error("software sequence too short or pin not driven");
   a_wdt_start: assert property (wdt_overflow && run && !bootstrap_mode && !bus_active
      |-> ##[1:2] internal_reset) else $error("watchdog reset missing");
   a_wdt_boot: assert property (wdt_overflow && run && bootstrap_mode
      && !software_reset_instruction |=> !internal_reset) else $error("loader reset");
   a_bidir_clear: assert property ($rose(reset_input_pin_oe) && !$past(bidir_reset_enable_wr)
      |-> !bidir_reset_enable) else $error("pin enable bit kept");
   a_pin_value: assert property (reset_input_pin_oe |-> !reset_input_pin_o)
      else $error("pin driven high");
   a_warm_float: assert property ($fell(reset_input_pin_i) && vpp_pin && !reset_input_pin_oe
      |-> ##[0:4] io_float) else $error("I/O not floated");
   a_idle_entry: assert property (idle_req && run && !bus_active && !ready_enabled && !cpu_halt
      |=> cpu_halt && !periph_halt) else $error("idle not entered");
endmodule

// ===== tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module tb_top;
   localparam int SEQ_LEN = 8;
   logic clk = 0, sys_rst = 1, vpp_pin = 0, software_reset_instruction = 0, wdt_overflow = 0;
   logic bootstrap_mode = 0, bidir_reset_enable_wr = 0, bidir_reset_enable_val = 0;
   logic bus_active = 0, bus_uses_ready = 0, waitstates_done = 0, ready_pin = 0;
   logic ready_enabled = 0, ready_polarity = 0, idle_req = 0, pdown_req = 0, pdown_hw_only = 0;
   logic irq_req = 0, fast_ext_irq = 0, button_low = 0, reset_input_pin_i, reset_input_pin_o;
   logic reset_input_pin_oe, reset_output_pin, bidir_reset_enable, io_float, internal_reset;
   logic hold_cancel, bus_abort, cpu_halt, periph_halt;
   int bad_count = 0, cmp_count = 0, seed = 83892, n;
   always #4 clk = ~clk;
   rst_seq #(.SEQ_LEN(SEQ_LEN)) dut (.*);
   ext_reset_model far (.pin_oe(reset_input_pin_oe), .pin_o(reset_input_pin_o),
      .button_low(button_low), .pin_level(reset_input_pin_i));
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick(1);
      s = 0;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   function automatic logic [11:0] seq_cycles(input int len);
      return 12'(len + 1); // Sequence plus the closing cycle
   endfunction
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait for the sequence to end; a hang is scored and closes the run
   task automatic count_reset(output int c);
      c = 0;
      while (internal_reset !== 1'b0 && c < 2000) begin
         c++;
         tick(1);
      end
      chk("reset_end", 1'b1, c < 2000);
      if (c >= 2000) stop_test();
   endtask
   initial begin
      tick(16);
      sys_rst = 0;
      tick(4);
      for (int k = 0; k < 2; k++) begin
         bidir_reset_enable_val = k[0];
         pulse(bidir_reset_enable_wr);
         chk("bidir_en", k[0], bidir_reset_enable);
         pulse(software_reset_instruction);
         chk("pin_oe", 1'b1, reset_input_pin_oe);
         chk("bidir_clr", 1'b0, bidir_reset_enable);
         count_reset(n);
         chk("sw_len", 1'b1, 12'(n) === seq_cycles(SEQ_LEN));
         bootstrap_mode = k[0];
         pulse(wdt_overflow);
         tick(1);
         chk("wdt_rst", !k[0], internal_reset);
         count_reset(n);
         bootstrap_mode = 0;
         {bus_active, bus_uses_ready, waitstates_done, ready_pin} = {3'h7, k[0]};
         pulse(wdt_overflow);
         chk("bus_abort", k[0], bus_abort);
         bus_active = 0;
         count_reset(n);
         $display("reset test %0d done", k);
      end
      button_low = 1;
      #1 chk("cold", 1'b1, internal_reset);
      tick(2);
      button_low = 0;
      #1 chk("resync", 1'b1, internal_reset);
      count_reset(n);
      vpp_pin = 1;
      button_low = 1;
      tick(5 + ($random(seed) & 7));
      chk("io_float", 1'b1, io_float);
      chk("rst_out", 1'b0, reset_output_pin);
      button_low = 0;
      count_reset(n);
      chk("warm_len", 1'b1, n > SEQ_LEN);
      vpp_pin = 0;
      ready_polarity = 1'($random(seed));
      bus_active = 1;
      pulse(idle_req);
      chk("refuse", 1'b0, cpu_halt);
      bus_active = 0;
      pulse(idle_req);
      chk("idle", 1'b1, cpu_halt & !periph_halt);
      irq_req = 1;
      tick(1 + ($random(seed) & 3));
      irq_req = 0;
      chk("idle_wake", 1'b0, cpu_halt);
      pulse(pdown_req);
      chk("pdown", 1'b1, periph_halt);
      fast_ext_irq = 1;
      tick(1);
      fast_ext_irq = 0;
      chk("pdown_wake", 1'b0, periph_halt);
      pdown_hw_only = 1;
      pulse(pdown_req);
      irq_req = 1;
      tick(1);
      irq_req = 0;
      chk("pdown_hw", 1'b1, periph_halt);
      fast_ext_irq = 1;
      tick(1);
      fast_ext_irq = 0;
      chk("pdown_fast", 1'b0, periph_halt);
      ready_enabled = 1;
      bus_active = 1;
      tick(1);
      bus_active = 0;
      pulse(idle_req);
      chk("ready_gate", ready_polarity, cpu_halt);
      irq_req = 1;
      tick(1);
      irq_req = 0;
      $display("power test done");
      stop_test();
   end
endmodule
bind rst_seq rst_seq_checker #(.SEQ_LEN(SEQ_LEN)) chk_i (.*);
